/* File: mtr_map.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * transparent Modbus router. Assumes byte addresses on an 8-bit APB address.
 */
`ifndef MTR_MAP_SVH
`define MTR_MAP_SVH
`define MTR_OFF_CTRL 8'h00
`define MTR_OFF_RSP_TMO 8'h04
`define MTR_OFF_ICT 8'h08
`define MTR_OFF_IFD 8'h0C
`define MTR_OFF_AUTO_CFG 8'h10
`define MTR_OFF_AUTO_RES 8'h14
`define MTR_OFF_MAP_SEL 8'h18
`define MTR_OFF_MAP_RANGE 8'h1C
`define MTR_OFF_MAP_IP 8'h20
`define MTR_OFF_MAP_PORT 8'h24
`define MTR_OFF_IRQ_STS 8'h28
`define MTR_OFF_IRQ_EN 8'h2C
`define MTR_OFF_IRQ_CLR 8'h30
`define MTR_OFF_STATE 8'h34
`define MTR_CTRL_EN 0
`define MTR_CTRL_ROLE_M 1
`define MTR_CTRL_ASCII 2
`define MTR_CTRL_AUTO 3
`define MTR_RNG_START 7:0
`define MTR_RNG_END 15:8
`define MTR_RNG_OFF 24:16
`define MTR_RNG_TCP 30
`define MTR_RNG_VALID 31
`define MTR_EV_UNMAPPED 0
`define MTR_EV_QFULL 1
`define MTR_EV_RSP_TMO 2
`define MTR_EV_ICT 3
`define MTR_EV_AUTO 4
`define MTR_EV_DONE 5
`define MTR_RST_RSP_TMO 17'h003E8
`define MTR_RST_ICT 9'h000
`define MTR_RST_IFD 9'h000
`define MTR_ID_MIN 8'h01
`define MTR_ID_MAX 8'hFE
`define MTR_TMO_MIN_MS 17'h0000A
`define MTR_AUTO_ICT_MS 17'h0000A
`define MTR_AUTO_IFD_MS 17'h0000A
`define MTR_PCLK_HZ 40000000
`define MTR_TICK_MS 1
`define MTR_CYC_PER_MS ((`MTR_PCLK_HZ / 1000) * `MTR_TICK_MS)
`endif

/* File: mtr_pkg.sv */
/*
 * Types of the transparent Modbus router. Constants live in mtr_map.svh.
 */
package mtr_pkg;
  typedef enum logic [3:0] {
    MTR_IDLE = 4'b0000,
    MTR_FETCH = 4'b0001,
    MTR_LOOKUP = 4'b0010,
    MTR_SEND = 4'b0011,
    MTR_WAIT_TX = 4'b0100,
    MTR_WAIT_RSP = 4'b0101,
    MTR_RX = 4'b0110,
    MTR_IFD = 4'b0111,
    MTR_DELIVER = 4'b1000
  } mtr_state_e;

  typedef struct packed {
    logic valid;
    logic tcp;
    logic [8:0] offset;
    logic [7:0] id_end;
    logic [7:0] id_start;
    logic [31:0] ip;
    logic [15:0] port;
  } mtr_map_s;

  typedef struct packed {
    logic [7:0] id;
    logic [15:0] tag;
  } mtr_req_s;

  typedef struct packed {
    logic tcp;
    logic probe;
    logic [7:0] id;
    logic [15:0] tag;
    logic [31:0] ip;
    logic [15:0] port;
    logic [7:0] fc;
    logic [15:0] addr;
  } mtr_fwd_s;

  typedef struct packed {
    logic [7:0] id;
    logic [15:0] tag;
  } mtr_rsp_s;
endpackage

/* File: mtr_qmem.sv */
/*
 * Request queue storage: one write port, one read port, registered read
 * data. Assumes the caller keeps its own pointers and never reads and
 * writes the same entry in one cycle with an expectation of bypass.
 */
module mtr_qmem #(
  parameter int W = 24,
  parameter int AW = 5
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read side
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (ce && re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // mtr_qmem

/* File: mtr_router.sv */
/*
 * Transparent Modbus router core: per-master request queues, virtual slave
 * ID map with offset translation, one-at-a-time forwarding, response
 * timeout, RTU inter-character discard, RTU inter-frame delay, response
 * timeout auto-detection and an APB register file with interrupt.
 * Assumes the byte-level framers and the TCP stack sit on pclk and give
 * one-cycle pulses; no input here needs synchronising.
 */
`include "mtr_map.svh"

// Behaviour
// RULE_01: serial master pairs with TCP server, serial slave pairs with TCP client.
// RULE_02: reply wait is 10 to 120000 ms, default 1000; expiry abandons the request.
// RULE_03: auto-detect measures reply time with chosen function and address, serial slaves only.
// RULE_04: RTU character gap above inter-character timeout discards the partial frame.
// RULE_05: inter-character timeout zero means an automatically chosen interval.
// RULE_06: RTU reply waits inter-frame delay before going upstream; zero means automatic.
// RULE_07: serial-slave role maps all IDs to serial; serial-master role starts empty.
// RULE_08: map entry spans virtual IDs 1 to 254, TCP entries carry IP and port.
// RULE_09: actual ID is virtual ID plus signed entry offset, -253 to 253.
// RULE_10: a request goes only to its mapped destination, never broadcast.
// RULE_11: mapped requests leave with the translated actual slave ID.
// RULE_12: requests with unmapped IDs are silently dropped.
// RULE_13: software must keep virtual ranges disjoint and clear of other TCP IDs.
// RULE_14: one request outstanding; next waits for reply or timeout.
// RULE_15: each master has a 32-deep pending queue; arrivals when full are dropped.
// RULE_16: framing is RTU or ASCII, RTU default; gap timers only in RTU.
// RULE_17: reply timer runs from last request character sent to first reply character.
module mtr_router #(
  parameter int NM = 2,
  parameter int NMAP = 4,
  parameter int QAW = 5,
  parameter int CYC_PER_MS = `MTR_CYC_PER_MS
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // role and framing
  output logic net_tcp_server,
  output logic ser_ascii,
  // upstream requests
  input wire logic req_valid,
  input wire logic [$clog2(NM)-1:0] req_master,
  input wire mtr_pkg::mtr_req_s req,
  // forwarded request
  output logic fwd_valid,
  input wire logic fwd_ready,
  output mtr_pkg::mtr_fwd_s fwd,
  input wire logic ser_tx_done,
  // reply events
  input wire logic ser_rx_char,
  input wire logic ser_rx_end,
  input wire logic tcp_rx_char,
  input wire logic tcp_rx_end,
  output logic rx_discard,
  // upstream reply
  output logic rsp_valid,
  input wire logic rsp_ready,
  output mtr_pkg::mtr_rsp_s rsp
);
  localparam int MW = (NM > 1) ? $clog2(NM) : 1;
  localparam logic [16:0] CPM = 17'(CYC_PER_MS - 1);

  typedef struct packed {
    mtr_pkg::mtr_state_e state;
    logic en;
    logic role_m;
    logic ascii;
    logic [16:0] rsp_tmo;
    logic [8:0] ict;
    logic [8:0] ifd;
    logic [31:0] acfg;
    logic [17:0] ares;
    logic [1:0] msel;
    mtr_pkg::mtr_map_s [NMAP-1:0] map;
    logic [5:0] sts;
    logic [5:0] ien;
    logic [NM-1:0][QAW-1:0] wp;
    logic [NM-1:0][QAW-1:0] rp;
    logic [NM-1:0][QAW:0] cnt;
    logic [MW-1:0] cur;
    logic [7:0] vid;
    mtr_pkg::mtr_fwd_s fwd;
    mtr_pkg::mtr_rsp_s rsp;
    logic [16:0] pre;
    logic [16:0] ms;
    logic discard;
    logic [31:0] rdata;
  } mtr_st_s;

  mtr_st_s q, d;
  logic [NMAP-1:0] hit;
  logic [QAW+MW-1:0] waddr, raddr;
  logic re;
  mtr_pkg::mtr_req_s qrd;

  // range check per map entry
  genvar g;
  generate
    for (g = 0; g < NMAP; g++) begin : g_hit
      assign hit[g] = q.map[g].valid && (q.map[g].id_start >= `MTR_ID_MIN) &&
                      (q.map[g].id_end <= `MTR_ID_MAX) &&
                      (qrd.id >= q.map[g].id_start) && (qrd.id <= q.map[g].id_end); // RULE_08
    end
  endgenerate

  assign waddr = {MW'(req_master), q.wp[req_master]};

  mtr_qmem #(
    .W($bits(mtr_pkg::mtr_req_s)),
    .AW(QAW + MW)
  ) u_qmem (
    .clk(pclk),
    .rst_n(presetn),
    .ce(pce),
    .we(req_valid && q.cnt[req_master] != (QAW+1)'(1 << QAW)),
    .waddr(waddr),
    .wdata(req),
    .re(re),
    .raddr(raddr),
    .rdata_q(qrd)
  );

  function automatic mtr_pkg::mtr_map_s mtr_default_map(input logic role_m);
    mtr_pkg::mtr_map_s m;
    m = '0;
    m.valid = !role_m; // RULE_07
    m.id_start = `MTR_ID_MIN;
    m.id_end = `MTR_ID_MAX;
    return m;
  endfunction

  logic wr_acc, rd_setup, ms_tick, ser_sel, rtu, rx_char, rx_end;
  logic [16:0] ict_lim, ifd_lim, sugg;
  logic [5:0] ev;
  int sel;

  always_comb begin
    d = q;
    ev = '0;
    re = 1'b0;
    raddr = '0;
    sel = 0;
    d.discard = 1'b0;
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    ms_tick = (q.pre == CPM);
    d.pre = ms_tick ? '0 : q.pre + 17'h00001;
    if (ms_tick && q.ms != 17'h1FFFF) begin
      d.ms = q.ms + 17'h00001;
    end
    ser_sel = !q.fwd.tcp;
    rtu = ser_sel && !q.ascii; // RULE_16
    rx_char = ser_sel ? ser_rx_char : tcp_rx_char;
    rx_end = ser_sel ? ser_rx_end : tcp_rx_end;
    ict_lim = (q.ict == '0) ? `MTR_AUTO_ICT_MS : {8'h00, q.ict}; // RULE_05
    ifd_lim = (q.ifd == '0) ? `MTR_AUTO_IFD_MS : {8'h00, q.ifd}; // RULE_06
    sugg = (q.ms < 17'h10000) ? {q.ms[15:0], 1'b0} : 17'h1FFFF;
    if (sugg < `MTR_TMO_MIN_MS) begin
      sugg = `MTR_TMO_MIN_MS;
    end

    // enqueue per master
    for (int m = 0; m < NM; m++) begin
      if (req_valid && req_master == MW'(m)) begin
        if (q.cnt[m] == (QAW+1)'(1 << QAW)) begin
          ev[`MTR_EV_QFULL] = 1'b1; // RULE_15
        end else begin
          d.wp[m] = q.wp[m] + QAW'(1);
          d.cnt[m] = q.cnt[m] + (QAW+1)'(1);
        end
      end
    end

    case (q.state)
      mtr_pkg::MTR_IDLE: begin
        for (int m = NM - 1; m >= 0; m--) begin
          if (q.cnt[m] != '0) begin
            sel = m;
          end
        end
        if (q.en && q.cnt[sel] != '0) begin
          re = 1'b1;
          raddr = {MW'(sel), q.rp[sel]};
          d.cur = MW'(sel);
          d.rp[sel] = q.rp[sel] + QAW'(1);
          d.cnt[sel] = d.cnt[sel] - (QAW+1)'(1); // RULE_14
          d.state = mtr_pkg::MTR_FETCH;
        end
      end
      mtr_pkg::MTR_FETCH: begin
        d.state = mtr_pkg::MTR_LOOKUP;
      end
      mtr_pkg::MTR_LOOKUP: begin
        d.state = mtr_pkg::MTR_IDLE;
        if (hit == '0) begin
          ev[`MTR_EV_UNMAPPED] = 1'b1; // RULE_12
        end else begin
          // no probe fields may leak into a plain forward
          d.fwd = '0;
          for (int i = NMAP - 1; i >= 0; i--) begin
            if (hit[i]) begin
              d.fwd.tcp = q.map[i].tcp; // RULE_10
              d.fwd.ip = q.map[i].ip;
              d.fwd.port = q.map[i].port;
              d.fwd.id = 8'({1'b0, qrd.id} + q.map[i].offset); // RULE_09 RULE_11
            end
          end
          d.fwd.probe = 1'b0;
          d.fwd.tag = qrd.tag;
          d.vid = qrd.id;
          d.state = mtr_pkg::MTR_SEND;
        end
      end
      mtr_pkg::MTR_SEND: begin
        if (fwd_ready) begin
          d.state = q.fwd.tcp ? mtr_pkg::MTR_WAIT_RSP : mtr_pkg::MTR_WAIT_TX;
          d.ms = '0;
          d.pre = '0;
        end
      end
      mtr_pkg::MTR_WAIT_TX: begin
        d.ms = '0;
        d.pre = '0;
        if (ser_tx_done) begin
          d.state = mtr_pkg::MTR_WAIT_RSP; // RULE_17
        end
      end
      mtr_pkg::MTR_WAIT_RSP: begin
        if (rx_char) begin
          d.state = mtr_pkg::MTR_RX; // RULE_17
          d.ms = '0;
          d.pre = '0;
          if (q.fwd.probe) begin
            d.ares = {1'b1, sugg}; // RULE_03
            ev[`MTR_EV_AUTO] = 1'b1;
          end
        end else if (q.ms >= q.rsp_tmo) begin
          ev[`MTR_EV_RSP_TMO] = 1'b1; // RULE_02
          ev[`MTR_EV_AUTO] = q.fwd.probe;
          d.state = mtr_pkg::MTR_IDLE;
        end
      end
      mtr_pkg::MTR_RX: begin
        if (rx_end) begin
          d.ms = '0;
          d.pre = '0;
          d.rsp.id = q.vid;
          d.rsp.tag = q.fwd.tag;
          if (q.fwd.probe) begin
            d.state = mtr_pkg::MTR_IDLE;
          end else begin
            d.state = rtu ? mtr_pkg::MTR_IFD : mtr_pkg::MTR_DELIVER;
          end
        end else if (rx_char) begin
          d.ms = '0;
          d.pre = '0;
        end else if (rtu && q.ms > ict_lim) begin
          d.discard = 1'b1; // RULE_04
          ev[`MTR_EV_ICT] = 1'b1;
          d.state = mtr_pkg::MTR_IDLE;
        end
      end
      mtr_pkg::MTR_IFD: begin
        if (q.ms >= ifd_lim) begin
          d.state = mtr_pkg::MTR_DELIVER; // RULE_06
        end
      end
      mtr_pkg::MTR_DELIVER: begin
        if (rsp_ready) begin
          ev[`MTR_EV_DONE] = 1'b1;
          d.state = mtr_pkg::MTR_IDLE;
        end
      end
      default: begin
        d.state = mtr_pkg::MTR_IDLE;
      end
    endcase

    // register writes
    if (wr_acc) begin
      case (paddr)
        `MTR_OFF_CTRL: begin
          d.en = pwdata[`MTR_CTRL_EN];
          d.ascii = pwdata[`MTR_CTRL_ASCII];
          d.role_m = pwdata[`MTR_CTRL_ROLE_M]; // RULE_01
          if (pwdata[`MTR_CTRL_ROLE_M] != q.role_m) begin
            d.map = '0;
            d.map[0] = mtr_default_map(pwdata[`MTR_CTRL_ROLE_M]); // RULE_07
          end
          // probe only toward serial slaves, from idle, never over a queue pop
          if (pwdata[`MTR_CTRL_AUTO] && !q.role_m && q.state == mtr_pkg::MTR_IDLE && !re) begin
            d.fwd = '0;
            d.ares[17] = 1'b0;
            d.fwd.probe = 1'b1; // RULE_03
            d.fwd.fc = q.acfg[7:0];
            d.fwd.addr = q.acfg[23:8];
            d.fwd.id = q.acfg[31:24];
            d.vid = q.acfg[31:24];
            d.state = mtr_pkg::MTR_SEND;
          end
        end
        `MTR_OFF_RSP_TMO: d.rsp_tmo = pwdata[16:0];
        `MTR_OFF_ICT: d.ict = pwdata[8:0];
        `MTR_OFF_IFD: d.ifd = pwdata[8:0];
        `MTR_OFF_AUTO_CFG: d.acfg = pwdata;
        `MTR_OFF_MAP_SEL: d.msel = pwdata[1:0];
        `MTR_OFF_MAP_RANGE: begin
          d.map[q.msel].id_start = pwdata[`MTR_RNG_START];
          d.map[q.msel].id_end = pwdata[`MTR_RNG_END];
          d.map[q.msel].offset = pwdata[`MTR_RNG_OFF];
          d.map[q.msel].tcp = pwdata[`MTR_RNG_TCP];
          d.map[q.msel].valid = pwdata[`MTR_RNG_VALID];
        end
        `MTR_OFF_MAP_IP: d.map[q.msel].ip = pwdata;
        `MTR_OFF_MAP_PORT: d.map[q.msel].port = pwdata[15:0];
        `MTR_OFF_IRQ_EN: d.ien = pwdata[5:0];
        default: begin
        end
      endcase
    end
    // hardware set wins over software clear
    d.sts = (q.sts & ~((wr_acc && paddr == `MTR_OFF_IRQ_CLR) ? pwdata[5:0] : 6'h00)) | ev;

    // read data captured in the setup phase
    if (rd_setup) begin
      case (paddr)
        `MTR_OFF_CTRL: d.rdata = {29'h0, q.ascii, q.role_m, q.en};
        `MTR_OFF_RSP_TMO: d.rdata = {15'h0, q.rsp_tmo};
        `MTR_OFF_ICT: d.rdata = {23'h0, q.ict};
        `MTR_OFF_IFD: d.rdata = {23'h0, q.ifd};
        `MTR_OFF_AUTO_CFG: d.rdata = q.acfg;
        `MTR_OFF_AUTO_RES: d.rdata = {q.ares[17], 14'h0, q.ares[16:0]};
        `MTR_OFF_MAP_SEL: d.rdata = {30'h0, q.msel};
        `MTR_OFF_MAP_RANGE: d.rdata = {q.map[q.msel].valid, q.map[q.msel].tcp, 5'h00,
                                       q.map[q.msel].offset, q.map[q.msel].id_end,
                                       q.map[q.msel].id_start};
        `MTR_OFF_MAP_IP: d.rdata = q.map[q.msel].ip;
        `MTR_OFF_MAP_PORT: d.rdata = {16'h0000, q.map[q.msel].port};
        `MTR_OFF_IRQ_STS: d.rdata = {26'h0, q.sts};
        `MTR_OFF_IRQ_EN: d.rdata = {26'h0, q.ien};
        `MTR_OFF_STATE: d.rdata = {12'h0, q.cnt[0][QAW:0], 10'h0, q.state};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= mtr_pkg::MTR_IDLE;
      q.rsp_tmo <= `MTR_RST_RSP_TMO; // RULE_02
      q.ict <= `MTR_RST_ICT;
      q.ifd <= `MTR_RST_IFD;
      q.map[0] <= '{valid: 1'b1, tcp: 1'b0, offset: 9'h000, id_end: `MTR_ID_MAX,
                    id_start: `MTR_ID_MIN, ip: 32'h0000_0000, port: 16'h0000}; // RULE_07
    end else if (pce) begin
      q <= d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr <= `MTR_OFF_STATE && paddr[1:0] == 2'b00);
  assign prdata = q.rdata;
  assign irq = |(q.sts & q.ien);
  assign net_tcp_server = q.role_m; // RULE_01
  assign ser_ascii = q.ascii; // RULE_16
  assign fwd_valid = (q.state == mtr_pkg::MTR_SEND);
  assign fwd = q.fwd;
  assign rx_discard = q.discard;
  assign rsp_valid = (q.state == mtr_pkg::MTR_DELIVER);
  assign rsp = q.rsp;
endmodule // mtr_router

/* File: mtr_router_assertions.sv */
/*
 * Port-level checker of the transparent Modbus router.
 * Assumes the single pclk domain with active-low async reset presetn.
 */
`include "mtr_map.svh"
module mtr_router_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  // role and framing
  input wire logic net_tcp_server,
  input wire logic ser_ascii,
  // traffic
  input wire logic fwd_valid,
  input wire logic fwd_ready,
  input wire mtr_pkg::mtr_fwd_s fwd,
  input wire logic rx_discard,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire mtr_pkg::mtr_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctrl;
  logic wr_irq;
  assign wr_ctrl = psel && penable && pwrite && paddr == `MTR_OFF_CTRL;
  assign wr_irq = psel && penable && pwrite &&
    (paddr == `MTR_OFF_IRQ_CLR || paddr == `MTR_OFF_IRQ_EN);
  sequence s_fwd_take;
    fwd_valid && fwd_ready;
  endsequence
  sequence s_fwd_wait;
    fwd_valid && !fwd_ready;
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_slverr_decode: assert property (pslverr == (psel && penable &&
    (paddr > `MTR_OFF_STATE || paddr[1:0] != 2'b00))) else $error("pslverr wrong");
  chk_role_write: assert property ($changed(net_tcp_server) |-> $past(wr_ctrl))
    else $error("role moved without write");
  chk_ascii_write: assert property ($changed(ser_ascii) |-> $past(wr_ctrl))
    else $error("framing moved without write");
  chk_fwd_hold: assert property (s_fwd_wait |=> fwd_valid && $stable(fwd))
    else $error("forward request dropped or changed");
  chk_one_out: assert property (s_fwd_take |=> !fwd_valid [*3])
    else $error("second forward too soon");
  chk_no_cross: assert property (fwd_valid |-> !rsp_valid)
    else $error("forward and reply together");
  chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("reply dropped or changed");
  chk_rsp_once: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
    else $error("reply delivered twice");
  chk_discard_pulse: assert property (rx_discard |=> !rx_discard)
    else $error("discard longer than a cycle");
  chk_discard_rtu: assert property (rx_discard |-> !ser_ascii)
    else $error("discard in ascii framing");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wr_irq))
    else $error("irq fell without write");
endmodule // mtr_router_assertions

bind mtr_router mtr_router_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .irq(irq),
  .net_tcp_server(net_tcp_server), .ser_ascii(ser_ascii), .fwd_valid(fwd_valid),
  .fwd_ready(fwd_ready), .fwd(fwd), .rx_discard(rx_discard), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp(rsp)
);

/* File: mtr_far_end.sv */
/*
 * Far-end model: a serial or TCP slave answering forwarded requests.
 * Assumes pclk domain; mode 0 replies, 1 stays silent, 2 stops mid-frame.
 */
module mtr_far_end (
  // clock and control
  input wire logic pclk,
  input wire logic [1:0] mode,
  // forward side
  input wire logic fwd_valid,
  input wire mtr_pkg::mtr_fwd_s fwd,
  output logic fwd_ready,
  output logic ser_tx_done,
  // reply side
  output logic ser_rx_char,
  output logic ser_rx_end,
  output logic tcp_rx_char,
  output logic tcp_rx_end,
  // observation
  output mtr_pkg::mtr_fwd_s seen,
  output time end_t
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tcp = 1'b0;
  int n_acc = 0;
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: if (tcp) tcp_rx_char <= 1'b1; else ser_rx_char <= 1'b1;
      1: if (tcp) tcp_rx_end <= 1'b1; else ser_rx_end <= 1'b1;
      default: ser_tx_done <= 1'b1;
    endcase
    if (k == 1) end_t = $time;
    @(posedge pclk);
    {ser_tx_done, ser_rx_char, ser_rx_end, tcp_rx_char, tcp_rx_end} <= '0;
  endtask
  initial begin
    {fwd_ready, ser_tx_done, ser_rx_char, ser_rx_end, tcp_rx_char, tcp_rx_end} = '0;
    seen = '0;
    end_t = 0;
    forever begin
      @(posedge pclk);
      if (fwd_valid === 1'b1) begin
        // alternate prompt and slow acceptance
        repeat (3 * (n_acc % 2)) @(posedge pclk);
        n_acc++;
        fwd_ready <= 1'b1;
        @(posedge pclk);
        fwd_ready <= 1'b0;
        seen = fwd;
        tcp = fwd.tcp;
        if (!tcp) pulse(2);
        if (mode != 2'd1) repeat (mode == 2'd2 ? 1 : 3) begin
          repeat (3) @(posedge pclk);
          pulse(0);
        end
        if (mode == 2'd0) pulse(1);
      end
    end
  end
endmodule // mtr_far_end

/* File: modbus_transparent_router_test.sv */
/*
 * Self-checking bench of the router with the far-end model.
 * Assumes 40 MHz pclk and a millisecond shortened to 4 cycles.
 */
`include "mtr_map.svh"
module modbus_transparent_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic req_valid = 0, rsp_ready = 0, err, req_master = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, net_tcp_server, ser_ascii, fwd_valid, fwd_ready;
  logic ser_tx_done, ser_rx_char, ser_rx_end, tcp_rx_char, tcp_rx_end, rx_discard, rsp_valid;
  logic [1:0] mode = 2'd0;
  mtr_pkg::mtr_req_s req = '0;
  mtr_pkg::mtr_fwd_s fwd, seen;
  mtr_pkg::mtr_rsp_s rsp, got;
  time end_t, t_rsp;
  int err_total = 0, checked = 0;
  int discards = 0;
  always @(posedge pclk) if (rx_discard === 1'b1) discards++;
  always #12.5 pclk = ~pclk;
  mtr_router #(.CYC_PER_MS(CPM)) i_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .net_tcp_server(net_tcp_server), .ser_ascii(ser_ascii), .req_valid(req_valid),
    .req_master(req_master), .req(req), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd(fwd),
    .ser_tx_done(ser_tx_done), .ser_rx_char(ser_rx_char), .ser_rx_end(ser_rx_end),
    .tcp_rx_char(tcp_rx_char), .tcp_rx_end(tcp_rx_end), .rx_discard(rx_discard),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  mtr_far_end i_far (.pclk(pclk), .mode(mode), .fwd_valid(fwd_valid), .fwd(fwd),
    .fwd_ready(fwd_ready), .ser_tx_done(ser_tx_done), .ser_rx_char(ser_rx_char),
    .ser_rx_end(ser_rx_end), .tcp_rx_char(tcp_rx_char), .tcp_rx_end(tcp_rx_end),
    .seen(seen), .end_t(end_t));
  task automatic check(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_sts(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `MTR_OFF_IRQ_STS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
    if (rd[b] !== 1'b1) hang();
    check(rd[b], 1);
  endtask
  task automatic send(input logic [7:0] id);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= {id, 8'hA5, id};
    @(posedge pclk);
    req_valid <= 1'b0;
  endtask
  // one request through the far end, judged on both sides
  task automatic xfer(input logic [7:0] id, input logic [7:0] act, input logic tcp);
    int n;
    send(id);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    if (n >= 2000) hang();
    t_rsp = $time;
    got = rsp;
    rsp_ready <= 1'b1;
    @(posedge pclk);
    rsp_ready <= 1'b0;
    check(seen.id, act);
    check(seen.tcp, tcp);
    check(got, {id, 8'hA5, id});
  endtask
  task automatic s_reset;
    check({net_tcp_server, ser_ascii}, 0);
    rdc(`MTR_OFF_CTRL, 32'h0);
    rdc(`MTR_OFF_RSP_TMO, 32'h3E8);
    rdc(`MTR_OFF_ICT, 32'h0);
    rdc(`MTR_OFF_IFD, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
  endtask
  task automatic s_role;
    apb(1'b1, `MTR_OFF_CTRL, 32'h7);
    @(posedge pclk);
    check(net_tcp_server, 1);
    check(ser_ascii, 1);
    send(8'h05);
    wait_sts(0);
    apb(1'b1, `MTR_OFF_CTRL, 32'h1);
  endtask
  task automatic s_fwd;
    apb(1'b1, `MTR_OFF_IRQ_EN, 32'h20);
    xfer(8'h07, 8'h07, 1'b0);
    check((t_rsp - end_t) >= 10 * CPM * 25, 1);
    rdc(`MTR_OFF_IRQ_STS, 32'h21);
    check(irq, 1);
    apb(1'b1, `MTR_OFF_IRQ_CLR, 32'h3F);
    @(posedge pclk);
    check(irq, 0);
  endtask
  task automatic s_map;
    // ranges kept disjoint: 16..20 serial, 30 on tcp
    apb(1'b1, `MTR_OFF_MAP_SEL, 32'h0);
    apb(1'b1, `MTR_OFF_MAP_RANGE, 32'h81F51410);
    apb(1'b1, `MTR_OFF_MAP_SEL, 32'h1);
    apb(1'b1, `MTR_OFF_MAP_IP, 32'h0A000002);
    apb(1'b1, `MTR_OFF_MAP_PORT, 32'h1F6);
    apb(1'b1, `MTR_OFF_MAP_RANGE, 32'hC0001E1E);
    xfer(8'd16, 8'd5, 1'b0);
    xfer(8'd20, 8'd9, 1'b0);
    xfer(8'd30, 8'd30, 1'b1);
    check(seen.ip, 32'h0A000002);
    check(seen.port, 16'h1F6);
    send(8'd21);
    wait_sts(0);
  endtask
  task automatic s_faults;
    apb(1'b1, `MTR_OFF_RSP_TMO, 32'd10);
    mode <= 2'd1;
    send(8'd16);
    wait_sts(2);
    mode <= 2'd2;
    send(8'd16);
    wait_sts(3);
    check(discards, 1);
    mode <= 2'd0;
    xfer(8'd17, 8'd6, 1'b0);
  endtask
  task automatic s_auto;
    // probe id 0x0C, start address 0x0012, function 0x03
    apb(1'b1, `MTR_OFF_AUTO_CFG, 32'h0C001203);
    apb(1'b1, `MTR_OFF_CTRL, 32'h9);
    wait_sts(4);
    check({seen.probe, seen.id, seen.fc}, {1'b1, 8'h0C, 8'h03});
    check(seen.addr, 16'h0012);
    rdc(`MTR_OFF_AUTO_RES, 32'h8000000A);
  endtask
  task automatic s_queue;
    apb(1'b1, `MTR_OFF_CTRL, 32'h0);
    for (int i = 0; i < 33; i++) begin
      req_valid <= 1'b1;
      req <= {8'd16, 8'(i), 8'h00};
      @(posedge pclk);
    end
    req_valid <= 1'b0;
    wait_sts(1);
    apb(1'b0, `MTR_OFF_STATE, 32'h0);
    check(rd[20:14], 32);
    // the second master keeps its own queue
    apb(1'b1, `MTR_OFF_IRQ_CLR, 32'h3F);
    req_master <= 1'b1;
    send(8'd16);
    req_master <= 1'b0;
    apb(1'b0, `MTR_OFF_IRQ_STS, 32'h0);
    check(rd[1], 0);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_role();
    s_fwd();
    s_map();
    s_faults();
    s_auto();
    s_queue();
    report_and_stop();
  end
endmodule // modbus_transparent_router_test
